// [design/ticr_pkg.sv]
// Constants for the timer interrupt clear register bank.
// Assumes a 32-bit APB slave port on the system clock and a
// word-aligned register window.
package ticr_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_MASK = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_RAW = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_MIS = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h00C;

    // ------------------------------------------------------------
    // Interrupt source fields, shared by every register
    // ------------------------------------------------------------
    localparam int SRC_N = 4;
    localparam int BIT_TIMA_TIMEOUT = 0;
    localparam int BIT_CAPA_MATCH = 1;
    localparam int BIT_CAPA_EVENT = 2;
    localparam int BIT_RTC = 3;

    typedef logic [SRC_N-1:0] ticr_src_t;
    typedef logic [DATA_W-1:0] ticr_word_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam ticr_src_t MASK_RESET = 4'h0;
    localparam ticr_src_t RAW_RESET = 4'h0;
    localparam ticr_src_t SRC_NONE = 4'h0;
    localparam ticr_word_t WORD_ZERO = 32'h0000_0000;

endpackage

// [design/ticr_irq_if.sv]
// Carrier between the register front end and the interrupt status core.
// Assumes both ends run on the same clock; the interface has no logic.
`timescale 1ns/1ps

interface ticr_irq_if;
    import ticr_pkg::*;

    ticr_src_t set_evt;
    ticr_src_t clear;
    ticr_src_t mask;
    ticr_src_t raw;
    ticr_src_t masked;

    modport core (
        input set_evt,
        input clear,
        input mask,
        output raw,
        output masked
    );

    modport ctrl (
        output set_evt,
        output clear,
        output mask,
        input raw,
        input masked
    );

endinterface

// [design/ticr_irq_core.sv]
// Sticky interrupt status bits for the timer A and real-time-clock sources.
// Assumes set and clear arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps

module ticr_irq_core (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Status carrier
    ticr_irq_if.core bus
);
    import ticr_pkg::*;

    // ------------------------------------------------------------
    // Raw status
    // ------------------------------------------------------------
    ticr_src_t raw;
    ticr_src_t next_raw;

    // A zero in the clear vector leaves its bit alone, and a set in
    // the same cycle as a clear wins so that no event is lost.
    // selective clear
    always_comb begin
        next_raw = (raw & ~bus.clear) | bus.set_evt;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            raw <= RAW_RESET;
        end else begin
            raw <= next_raw;
        end
    end

    assign bus.raw = raw;

    // ------------------------------------------------------------
    // Masked status
    // ------------------------------------------------------------
    // Derived from raw, so a clear drops both views together.
    // masked follows raw
    assign bus.masked = raw & bus.mask;

endmodule

// [design/ticr_top.sv]
// APB register bank holding the interrupt mask, raw and masked status
// and the write-one-to-clear register of the timer A / RTC sources.
// Assumes event pulses come from timer logic on the same clock.
//
// Operation
// - Writing one to bit 3 of the clear register clears the RTC interrupt.
// - Writing one to bit 2 clears the capture A event interrupt.
// - Bit 1 is write-one-to-clear for capture A match, reset value zero.
// - Bit 0 is write-one-to-clear for the timer A time-out interrupt.
// - Writing zero to a clear field leaves that interrupt untouched.
`timescale 1ns/1ps

module ticr_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ticr_pkg::ADDR_W-1:0] paddr,
    input wire logic [ticr_pkg::DATA_W-1:0] pwdata,
    output logic [ticr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt events from the timer
    input wire logic tima_timeout_evt,
    input wire logic capa_match_evt,
    input wire logic capa_event_evt,
    input wire logic rtc_match_evt,
    // Interrupt request
    output logic irq
);
    import ticr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] offset
    );
        reg_hit = (addr == offset);
    endfunction

    function automatic ticr_word_t widen(input ticr_src_t value);
        widen = {{(DATA_W-SRC_N){1'b0}}, value};
    endfunction

    // ------------------------------------------------------------
    // Status carrier and core
    // ------------------------------------------------------------
    ticr_irq_if irq_bus ();

    ticr_irq_core core (
        .clock(clock),
        .reset_n(reset_n),
        .bus(irq_bus)
    );

    // ------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic write_done;
    logic hit_mask;
    logic hit_raw;
    logic hit_mis;
    logic hit_clear;
    logic hit_any;

    assign setup_phase = psel && !penable;
    assign write_done = psel && penable && pready && pwrite;

    always_comb begin
        hit_mask = 1'b0;
        hit_raw = 1'b0;
        hit_mis = 1'b0;
        hit_clear = 1'b0;
        if (reg_hit(paddr, OFF_MASK)) begin
            hit_mask = 1'b1;
        end else if (reg_hit(paddr, OFF_RAW)) begin
            hit_raw = 1'b1;
        end else if (reg_hit(paddr, OFF_MIS)) begin
            hit_mis = 1'b1;
        end else if (reg_hit(paddr, OFF_CLEAR)) begin
            hit_clear = 1'b1;
        end
    end

    assign hit_any = hit_mask || hit_raw || hit_mis || hit_clear;

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    // Every access completes in the first access cycle. Ready is
    // registered so that the bus sees a clean flop output.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_phase && !hit_any;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data is captured at setup, so it shows the state one
    // cycle before the access edge. The clear register reads zero,
    // as do unmapped addresses and all bits above the four fields.
    ticr_word_t next_prdata;

    always_comb begin
        next_prdata = WORD_ZERO;
        if (hit_mask) begin
            next_prdata = widen(irq_bus.mask);
        end else if (hit_raw) begin
            next_prdata = widen(irq_bus.raw);
        end else if (hit_mis) begin
            next_prdata = widen(irq_bus.masked);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= WORD_ZERO;
        end else if (setup_phase && !pwrite) begin
            prdata <= next_prdata;
        end else if (!psel) begin
            prdata <= WORD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Mask register
    // ------------------------------------------------------------
    ticr_src_t mask;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mask <= MASK_RESET;
        end else if (write_done && hit_mask) begin
            mask <= pwdata[SRC_N-1:0];
        end
    end

    // ------------------------------------------------------------
    // Clear register and events
    // ------------------------------------------------------------
    // The clear register stores nothing: each field is a strobe that
    // exists only at the completing edge of the write.
    ticr_src_t clear_vec;

    always_comb begin
        clear_vec = SRC_NONE;
        if (write_done && hit_clear) begin
            clear_vec[BIT_RTC] = pwdata[BIT_RTC];
            clear_vec[BIT_CAPA_EVENT] = pwdata[BIT_CAPA_EVENT];
            clear_vec[BIT_CAPA_MATCH] = pwdata[BIT_CAPA_MATCH];
            clear_vec[BIT_TIMA_TIMEOUT] = pwdata[BIT_TIMA_TIMEOUT];
        end
    end

    ticr_src_t set_vec;

    always_comb begin
        set_vec = SRC_NONE;
        set_vec[BIT_TIMA_TIMEOUT] = tima_timeout_evt;
        set_vec[BIT_CAPA_MATCH] = capa_match_evt;
        set_vec[BIT_CAPA_EVENT] = capa_event_evt;
        set_vec[BIT_RTC] = rtc_match_evt;
    end

    assign irq_bus.set_evt = set_vec;
    assign irq_bus.clear = clear_vec;
    assign irq_bus.mask = mask;

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    // One cycle behind the masked status, traded for a flop output.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |irq_bus.masked;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_rtc_clear: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && pwdata[BIT_RTC] && !rtc_match_evt)
        |=> !irq_bus.raw[BIT_RTC]
    ) else $error("rtc interrupt not cleared by write of one");

    chk_capev_clear: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && pwdata[BIT_CAPA_EVENT])
        ##0 !capa_event_evt
        |=> (irq_bus.raw[BIT_CAPA_EVENT] == 1'b0)
    ) else $error("capture event interrupt not cleared");

    chk_capmatch_clear: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && pwdata[BIT_CAPA_MATCH])
        && !capa_match_evt && !$past(capa_match_evt)
        |=> !irq_bus.raw[BIT_CAPA_MATCH] && !irq_bus.masked[BIT_CAPA_MATCH]
    ) else $error("capture match interrupt not cleared");

    chk_capmatch_reset: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(reset_n) |-> !irq_bus.raw[BIT_CAPA_MATCH]
    ) else $error("capture match status not zero after reset");

    chk_timeout_clear: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && pwdata[BIT_TIMA_TIMEOUT]
            && !tima_timeout_evt)
        |=> !irq_bus.raw[BIT_TIMA_TIMEOUT]
            && !irq_bus.masked[BIT_TIMA_TIMEOUT]
    ) else $error("timer timeout interrupt not cleared");

    chk_zero_keeps: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && !pwdata[BIT_TIMA_TIMEOUT]
            && irq_bus.raw[BIT_TIMA_TIMEOUT])
        |=> irq_bus.raw[BIT_TIMA_TIMEOUT]
    ) else $error("writing zero disturbed timeout status");

    chk_zero_keeps_rtc: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && !pwdata[BIT_RTC]
            && irq_bus.raw[BIT_RTC])
        |=> $stable(irq_bus.raw[BIT_RTC])
    ) else $error("writing zero disturbed rtc status");

    chk_masked_drop: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && (pwdata[SRC_N-1:0] != SRC_NONE)
            && (set_vec == SRC_NONE))
        |=> ((irq_bus.masked & $past(pwdata[SRC_N-1:0])) == SRC_NONE)
    ) else $error("masked status survived a clear");

    chk_set_wins: assert property (
        @(posedge clock) disable iff (!reset_n)
        (rtc_match_evt && write_done && hit_clear && pwdata[BIT_RTC])
        |=> irq_bus.raw[BIT_RTC]
    ) else $error("event lost against a same-cycle clear");

    chk_ready_timing: assert property (
        @(posedge clock) disable iff (!reset_n)
        setup_phase |=> pready ##1 !pready
    ) else $error("ready did not follow setup by one cycle");

    chk_clear_reads_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        (setup_phase && !pwrite && hit_clear) |=> (prdata == WORD_ZERO)
    ) else $error("clear register did not read zero");

    chk_err_unmapped: assert property (
        @(posedge clock) disable iff (!reset_n)
        (setup_phase && !hit_any) |=> (pready && pslverr)
    ) else $error("unmapped access not refused");

    chk_irq_high: assert property (
        @(posedge clock) disable iff (!reset_n)
        (irq_bus.masked != SRC_NONE) |=> irq
    ) else $error("irq low while an unmasked status bit is set");

    chk_irq_low: assert property (
        @(posedge clock) disable iff (!reset_n)
        (irq_bus.masked == SRC_NONE) |=> !irq
    ) else $error("irq high with no unmasked status bit");

    chk_zero_keeps_capev: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && !pwdata[BIT_CAPA_EVENT]
            && irq_bus.raw[BIT_CAPA_EVENT])
        |=> irq_bus.raw[BIT_CAPA_EVENT]
    ) else $error("writing zero disturbed capture event status");

    chk_zero_keeps_capmatch: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_done && hit_clear && !pwdata[BIT_CAPA_MATCH]
            && irq_bus.raw[BIT_CAPA_MATCH])
        |=> irq_bus.raw[BIT_CAPA_MATCH]
    ) else $error("writing zero disturbed capture match status");

endmodule

// [bench/tb_ticr_top.sv]
// Self-checking bench for the timer interrupt clear register bank.
// Assumes the design package and the top module are compiled first.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", nm, exp, got); \
    end end

module tb_ticr_top;
    import ticr_pkg::*;

    logic clock;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    ticr_word_t pwdata;
    ticr_word_t prdata;
    logic pready;
    logic pslverr;
    ticr_src_t evt;
    logic irq;
    int num_errors;
    int n_tests;
    ticr_word_t rd;
    logic err;
    int waits;

    ticr_top i_ticr_top (
        .clock(clock),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .tima_timeout_evt(evt[BIT_TIMA_TIMEOUT]),
        .capa_match_evt(evt[BIT_CAPA_MATCH]),
        .capa_event_evt(evt[BIT_CAPA_EVENT]),
        .rtc_match_evt(evt[BIT_RTC]),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Bus and event drivers
    // ------------------------------------------------------------
    // One full transfer; an idle edge first keeps drivers from
    // assigning the strobes twice in one time step.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input ticr_word_t d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        waits = 0;
        do begin
            @(posedge clock);
            waits++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input ticr_src_t s);
        @(posedge clock);
        evt <= s;
        @(posedge clock);
        evt <= SRC_NONE;
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input ticr_word_t e);
        apb(1'b0, a, WORD_ZERO);
        `CHK("read data", e, rd)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(OFF_MASK, WORD_ZERO);
        `CHK("ready cycles", 1, waits)
        rd_chk(OFF_RAW, WORD_ZERO);
        rd_chk(OFF_MIS, WORD_ZERO);
        rd_chk(OFF_CLEAR, WORD_ZERO);
        `CHK("irq", 1'b0, irq)
        $display("test reset done");
    endtask

    task automatic t_each_bit();
        for (int i = 0; i < SRC_N; i++) begin
            pulse(4'hF);
            rd_chk(OFF_RAW, 32'h0000_000F);
            apb(1'b1, OFF_CLEAR, WORD_ZERO);
            rd_chk(OFF_RAW, 32'h0000_000F);
            apb(1'b1, OFF_CLEAR, 32'h1 << i);
            rd_chk(OFF_RAW, 32'hF & ~(32'h1 << i));
            apb(1'b1, OFF_CLEAR, 32'h0000_000F);
            rd_chk(OFF_RAW, WORD_ZERO);
        end
        $display("test single clears done");
    endtask

    task automatic t_masked();
        apb(1'b1, OFF_MASK, 32'h0000_000A);
        pulse(4'hF);
        @(posedge clock);
        `CHK("irq", 1'b1, irq)
        rd_chk(OFF_MIS, 32'h0000_000A);
        apb(1'b1, OFF_CLEAR, 32'h0000_0002);
        rd_chk(OFF_MIS, 32'h0000_0008);
        rd_chk(OFF_RAW, 32'h0000_000D);
        @(posedge clock);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, OFF_CLEAR, 32'h0000_0008);
        rd_chk(OFF_MIS, WORD_ZERO);
        rd_chk(OFF_RAW, 32'h0000_0005);
        @(posedge clock);
        `CHK("irq", 1'b0, irq)
        apb(1'b1, OFF_CLEAR, 32'h0000_0005);
        apb(1'b1, OFF_MASK, WORD_ZERO);
        $display("test masked status done");
    endtask

    task automatic t_refused();
        pulse(4'h4);
        apb(1'b0, 12'h010, WORD_ZERO);
        `CHK("slave error", 1'b1, err)
        `CHK("error data", WORD_ZERO, rd)
        apb(1'b1, OFF_RAW, 32'h0000_0004);
        `CHK("slave error", 1'b0, err)
        rd_chk(OFF_RAW, 32'h0000_0004);
        apb(1'b1, OFF_CLEAR, 32'h0000_0004);
        rd_chk(OFF_RAW, WORD_ZERO);
        $display("test refused accesses done");
    endtask

    // An event at the very edge that completes a clear of its bit.
    task automatic t_set_wins();
        fork
            apb(1'b1, OFF_CLEAR, 32'h0000_0008);
            begin
                repeat (2) @(posedge clock);
                evt <= 4'h8;
                @(posedge clock);
                evt <= SRC_NONE;
            end
        join
        rd_chk(OFF_RAW, 32'h0000_0008);
        apb(1'b1, OFF_CLEAR, 32'h0000_0008);
        rd_chk(OFF_RAW, WORD_ZERO);
        $display("test set against clear done");
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and verdict
    // ------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        #200000;
        num_errors++;
        results();
    end

    initial begin
        num_errors = 0;
        n_tests = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = WORD_ZERO;
        evt = SRC_NONE;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_each_bit();
        t_masked();
        t_refused();
        t_set_wins();
        results();
    end
endmodule
